// file: src/itbu_top.sv
// interrupt control, priority, stack handling, wake-up and time base clocking
`timescale 1ns/1ps
`default_nettype none
`include "itbu_defines.svh"
module itbu_top (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// peripheral events and pin
	input wire logic pin_in,
	input wire logic pin_func_sel,
	input wire logic pin_dir_in,
	input wire logic pin_pullup_sel,
	output logic pin_pullup_en,
	input wire logic filter_output_ready,
	input wire logic ser_byte_done,
	input wire logic ser_addr_match,
	input wire logic ser_bus_timeout,
	input wire logic sub_clk_tick,
	// core side
	input wire itbu_pkg::itbu_pc_t next_pc,
	input wire logic core_can_take,
	input wire logic return_from_interrupt,
	input wire logic sleep_mode,
	output logic irq_take,
	output itbu_pkg::itbu_pc_t irq_vector,
	output logic irq_return,
	output itbu_pkg::itbu_pc_t return_pc,
	output logic stack_full,
	output logic wake_up
);
	import itbu_pkg::*;
	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic wr_pend, next_wr_pend;
	logic [11:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic [1:0] psc_src, next_psc_src;
	logic [7:0] time_base0_control, next_time_base0_control, time_base1_control, next_time_base1_control;
	logic [1:0] pin_edge_select, next_pin_edge_select;
	logic global_irq_enable, next_global_irq_enable;
	logic [4:0] irq_enable, next_irq_enable;
	logic [4:0] irq_flag, next_irq_flag;
	logic rd_go, wr_go;
	// keep only implemented time base bits so others read as zero
	function automatic logic [7:0] tb_mask(input logic [7:0] v);
		tb_mask = {v[7], 4'h0, v[2:0]};
	endfunction
	assign wr_go = hsel & hready & htrans[1] & hwrite;
	assign rd_go = hsel & hready & htrans[1] & ~hwrite;
	// every register answers at once, so the slave never stretches a transfer
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// ------------------------------------------------------------
	// prescaler and time bases
	// ------------------------------------------------------------
	logic [1:0] div4, next_div4;
	logic psc_en;
	itbu_tick_if tb0_if ();
	itbu_tick_if tb1_if ();
	always_comb begin
		next_div4 = div4 + 2'd1;
		if (psc_src[1]) begin
			psc_en = sub_clk_tick;
		end else if (psc_src[0]) begin
			psc_en = (div4 == `ITBU_PSC_DIV4);
		end else begin
			psc_en = 1'b1;
		end
	end
	// time base 0 run bit and period
	assign tb0_if.run = time_base0_control[`ITBU_TB_RUN_BIT];
	assign tb0_if.period = time_base0_control[2:0];
	assign tb0_if.psc_en = psc_en;
	// time base 1 run bit and period
	assign tb1_if.run = time_base1_control[`ITBU_TB_RUN_BIT];
	assign tb1_if.period = time_base1_control[2:0];
	assign tb1_if.psc_en = psc_en;
	itbu_tick u_tb0 (.clk(clk), .nrst(nrst), .tb(tb0_if.tick));
	itbu_tick u_tb1 (.clk(clk), .nrst(nrst), .tb(tb1_if.tick));
	// ------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------
	logic pin_prev, filt_prev, pin_active, pin_edge;
	logic [4:0] events;
	// pin qualified by enable, function select and direction
	assign pin_active = irq_enable[`ITBU_SRC_PIN] & pin_func_sel & pin_dir_in;
	assign pin_pullup_en = pin_pullup_sel;
	always_comb begin
		case (pin_edge_select)
			2'b01: pin_edge = pin_in & ~pin_prev;
			2'b10: pin_edge = ~pin_in & pin_prev;
			2'b11: pin_edge = pin_in ^ pin_prev;
			default: pin_edge = 1'b0;
		endcase
		// selected edge on the active pin
		events[`ITBU_SRC_PIN] = pin_active & pin_edge;
		events[`ITBU_SRC_FILT] = filter_output_ready & ~filt_prev;
		events[`ITBU_SRC_SER] = ser_byte_done | ser_addr_match | ser_bus_timeout;
		events[`ITBU_SRC_TB0] = tb0_if.overflow;
		events[`ITBU_SRC_TB1] = tb1_if.overflow;
	end
	// ------------------------------------------------------------
	// priority, stack and sequencing
	// ------------------------------------------------------------
	itbu_state_t state, next_state;
	itbu_pc_t stack_mem [0:`ITBU_STACK_DEPTH-1];
	logic [2:0] sp, next_sp;
	logic [4:0] pending;
	logic [2:0] sel;
	logic any_req, take;
	itbu_pc_t next_irq_vector, next_return_pc;
	logic next_irq_take, next_irq_return, next_wake_up;
	logic ret_wait, next_ret_wait, ret_due;
	// a return seen in a busy cycle waits here; with an empty stack it is dropped
	assign ret_due = (return_from_interrupt | ret_wait) & (sp != 3'd0);
	function automatic itbu_pc_t vec_of(input logic [2:0] s);
		case (s)
			3'd0: vec_of = `ITBU_VEC_PIN;
			3'd1: vec_of = `ITBU_VEC_FILT;
			3'd2: vec_of = `ITBU_VEC_SER;
			3'd3: vec_of = `ITBU_VEC_TB0;
			default: vec_of = `ITBU_VEC_TB1;
		endcase
	endfunction
	assign pending = irq_flag & irq_enable;
	// the pointer counts used entries; at the depth every slot holds a pc
	assign stack_full = (sp == 3'(`ITBU_STACK_DEPTH));
	assign any_req = global_irq_enable & (|pending) & ~stack_full;
	always_comb begin
		sel = 3'd4;
		for (int i = `ITBU_NSRC; i >= 0; i--) begin
			if (pending[i]) begin
				sel = 3'(i);
			end
		end
	end
	// a due return goes first, so a waiting interrupt then pushes the resumed pc
	assign take = (state == ITBU_RUN) & any_req & core_can_take & ~ret_due;
	always_comb begin
		next_state = state;
		next_sp = sp;
		next_ret_wait = ret_due;
		next_irq_take = 1'b0;
		next_irq_return = 1'b0;
		next_irq_vector = irq_vector;
		next_return_pc = return_pc;
		case (state)
			ITBU_RUN: begin
				if (take) begin
					// push next pc and load vector
					next_irq_take = 1'b1;
					next_irq_vector = vec_of(sel);
					next_sp = sp + 3'd1;
					next_state = ITBU_TAKE;
				end else if (ret_due) begin
					next_ret_wait = 1'b0;
					next_irq_return = 1'b1;
					next_return_pc = stack_mem[sp[1:0] - 2'd1];
					next_sp = sp - 3'd1;
					next_state = ITBU_RET;
				end
			end
			ITBU_TAKE: next_state = ITBU_RUN;
			ITBU_RET: next_state = ITBU_RUN;
			default: next_state = ITBU_RUN;
		endcase
	end
	// ------------------------------------------------------------
	// register file next values
	// ------------------------------------------------------------
	always_comb begin
		next_wr_pend = wr_go;
		next_wr_addr = wr_go ? haddr : wr_addr;
		next_psc_src = psc_src;
		next_time_base0_control = time_base0_control;
		next_time_base1_control = time_base1_control;
		next_pin_edge_select = pin_edge_select;
		next_global_irq_enable = global_irq_enable;
		next_irq_enable = irq_enable;
		next_irq_flag = irq_flag;
		if (wr_pend) begin
			case (wr_addr)
				`ITBU_OFS_PSC: next_psc_src = hwdata[1:0];
				`ITBU_OFS_TB0: next_time_base0_control = tb_mask(hwdata[7:0]);
				`ITBU_OFS_TB1: next_time_base1_control = tb_mask(hwdata[7:0]);
				`ITBU_OFS_CTRL: begin
					next_global_irq_enable = hwdata[`ITBU_CTRL_GIE_BIT];
					next_irq_enable = hwdata[5:1];
				end
				`ITBU_OFS_EDGE: next_pin_edge_select = hwdata[1:0];
				`ITBU_OFS_FLAG: next_irq_flag = hwdata[4:0];
				default: next_wr_pend = wr_go;
			endcase
		end
		if (take) begin
			next_global_irq_enable = 1'b0;
			next_irq_flag[sel] = 1'b0;
		end else if (next_irq_return) begin
			next_global_irq_enable = 1'b1;
		end
		// hardware set wins; flags still latch while blocked
		next_irq_flag = next_irq_flag | events;
		// only a flag going low to high wakes
		next_wake_up = sleep_mode & |(events & ~irq_flag);
		// read data is captured in the address phase and held for the data phase
		case (haddr)
			`ITBU_OFS_PSC: next_hrdata = {30'h0, psc_src};
			`ITBU_OFS_TB0: next_hrdata = {24'h0, time_base0_control};
			`ITBU_OFS_TB1: next_hrdata = {24'h0, time_base1_control};
			`ITBU_OFS_CTRL: next_hrdata = {26'h0, irq_enable, global_irq_enable};
			`ITBU_OFS_EDGE: next_hrdata = {30'h0, pin_edge_select};
			`ITBU_OFS_FLAG: next_hrdata = {27'h0, irq_flag};
			`ITBU_OFS_STAT: next_hrdata = {28'h0, stack_full, sp};
			default: next_hrdata = 32'h0000_0000;
		endcase
		if (!rd_go) begin
			next_hrdata = hrdata;
		end
	end
	// ------------------------------------------------------------
	// bus and flag registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			psc_src <= 2'b00;
			time_base0_control <= `ITBU_RST_BYTE;
			time_base1_control <= `ITBU_RST_BYTE;
			pin_edge_select <= 2'b00;
			global_irq_enable <= 1'b0;
			irq_enable <= 5'h00;
			irq_flag <= 5'h00;
			wake_up <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			psc_src <= next_psc_src;
			time_base0_control <= next_time_base0_control;
			time_base1_control <= next_time_base1_control;
			pin_edge_select <= next_pin_edge_select;
			global_irq_enable <= next_global_irq_enable;
			irq_enable <= next_irq_enable;
			irq_flag <= next_irq_flag;
			wake_up <= next_wake_up;
		end
	end
	// ------------------------------------------------------------
	// prescaler and edge sample registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div4 <= 2'd0;
			pin_prev <= 1'b0;
			filt_prev <= 1'b0;
		end else begin
			div4 <= next_div4;
			pin_prev <= pin_in;
			filt_prev <= filter_output_ready;
		end
	end
	// ------------------------------------------------------------
	// sequencer registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ITBU_RUN;
			sp <= 3'd0;
			ret_wait <= 1'b0;
			irq_take <= 1'b0;
			irq_return <= 1'b0;
			irq_vector <= 11'h000;
			return_pc <= 11'h000;
		end else begin
			state <= next_state;
			sp <= next_sp;
			ret_wait <= next_ret_wait;
			irq_take <= next_irq_take;
			irq_return <= next_irq_return;
			irq_vector <= next_irq_vector;
			return_pc <= next_return_pc;
		end
	end
	// stack words need no reset; the pointer guards them
	always_ff @(posedge clk) begin
		if (take) begin
			stack_mem[sp[1:0]] <= next_pc;
		end
	end
endmodule // itbu_top
`default_nettype wire

// file: src/itbu_defines.svh
// register offsets, field positions, reset values and timing counts of the interrupt unit
`ifndef ITBU_DEFINES_SVH
`define ITBU_DEFINES_SVH
`define ITBU_OFS_PSC 12'h000
`define ITBU_OFS_TB0 12'h004
`define ITBU_OFS_TB1 12'h008
`define ITBU_OFS_CTRL 12'h00C
`define ITBU_OFS_EDGE 12'h010
`define ITBU_OFS_FLAG 12'h014
`define ITBU_OFS_STAT 12'h018
`define ITBU_RST_BYTE 8'h00
`define ITBU_TB_RUN_BIT 7
`define ITBU_CTRL_GIE_BIT 0
`define ITBU_NSRC 4
`define ITBU_SRC_PIN 0
`define ITBU_SRC_FILT 1
`define ITBU_SRC_SER 2
`define ITBU_SRC_TB0 3
`define ITBU_SRC_TB1 4
`define ITBU_STACK_DEPTH 4
`define ITBU_PC_W 11
`define ITBU_VEC_PIN 11'h004
`define ITBU_VEC_FILT 11'h008
`define ITBU_VEC_SER 11'h00C
`define ITBU_VEC_TB0 11'h010
`define ITBU_VEC_TB1 11'h014
`define ITBU_PSC_DIV4 2'd3
`endif

// file: src/itbu_pkg.sv
// types shared by the interrupt and time base unit
package itbu_pkg;
	typedef enum logic [1:0] {
		ITBU_RUN = 2'b00,
		ITBU_TAKE = 2'b01,
		ITBU_RET = 2'b10
	} itbu_state_t;
	typedef logic [10:0] itbu_pc_t;
endpackage

// file: src/itbu_tick_if.sv
// time base control and overflow signals between the unit and a time base
`timescale 1ns/1ps
`default_nettype none
interface itbu_tick_if;
	logic run;
	logic [2:0] period;
	logic psc_en;
	logic overflow;
	modport owner (output run, output period, output psc_en, input overflow);
	modport tick (input run, input period, input psc_en, output overflow);
endinterface
`default_nettype wire

// file: src/itbu_tick.sv
// one time base: free counter on prescaler enables with selectable overflow bit
`timescale 1ns/1ps
`default_nettype none
`include "itbu_defines.svh"
module itbu_tick (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control
	itbu_tick_if.tick tb
);
	import itbu_pkg::*;
	logic [15:0] count;
	logic [15:0] next_count;
	logic next_ovf;
	logic ovf;
	always_comb begin
		next_count = count;
		next_ovf = 1'b0;
		if (!tb.run) begin
			next_count = 16'h0000;
		end else if (tb.psc_en) begin
			next_count = count + 16'h0001;
			// overflow of bit 7+period: period of 2^(8+period) prescaler clocks
			next_ovf = count[4'd7 + {1'b0, tb.period}] & ~next_count[4'd7 + {1'b0, tb.period}];
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= 16'h0000;
			ovf <= 1'b0;
		end else begin
			count <= next_count;
			ovf <= next_ovf;
		end
	end
	assign tb.overflow = ovf;
endmodule // itbu_tick
`default_nettype wire

// file: tb/itbu_checker.sv
// port-level assertion checker for the interrupt and time base unit
`timescale 1ns/1ps
`default_nettype none
module itbu_checker (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// watched ports
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic pin_pullup_sel,
	input wire logic pin_pullup_en,
	input wire logic sleep_mode,
	input wire logic irq_take,
	input wire itbu_pkg::itbu_pc_t irq_vector,
	input wire logic irq_return,
	input wire logic stack_full,
	input wire logic wake_up
);
	import itbu_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----
	// properties
	// ----
	take_spacing_a: assert property (irq_take |=> !irq_take) else $error("take repeated");
	full_blocks_a: assert property (stack_full |=> !irq_take) else $error("take on full");
	vector_set_a: assert property (irq_take |-> irq_vector inside {11'h004, 11'h008,
		11'h00C, 11'h010, 11'h014}) else $error("bad vector");
	take_or_ret_a: assert property (!(irq_take && irq_return)) else $error("take and return");
	ret_room_a: assert property (irq_return |-> !stack_full) else $error("full after pop");
	wake_sleep_a: assert property (wake_up |-> $past(sleep_mode)) else $error("wake awake");
	pullup_kept_a: assert property (pin_pullup_en == pin_pullup_sel) else $error("pull");
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer");
endmodule // itbu_checker
bind itbu_top itbu_checker chk_i (.clk(clk), .nrst(nrst), .hreadyout(hreadyout),
	.hresp(hresp), .pin_pullup_sel(pin_pullup_sel), .pin_pullup_en(pin_pullup_en),
	.sleep_mode(sleep_mode), .irq_take(irq_take), .irq_vector(irq_vector),
	.irq_return(irq_return), .stack_full(stack_full), .wake_up(wake_up));
`default_nettype wire

// file: tb/itbu_core_model.sv
// core fetch model: shows next pc, jumps to vectors, issues returns on request
`timescale 1ns/1ps
`default_nettype none
module itbu_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// unit side
	input wire logic irq_take,
	input wire itbu_pkg::itbu_pc_t irq_vector,
	input wire logic irq_return,
	input wire itbu_pkg::itbu_pc_t return_pc,
	input wire logic do_ret,
	output itbu_pkg::itbu_pc_t next_pc,
	output logic core_can_take,
	output logic return_from_interrupt
);
	import itbu_pkg::*;
	assign core_can_take = 1'b1;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			next_pc <= 11'h123;
			return_from_interrupt <= 1'b0;
		end else begin
			return_from_interrupt <= do_ret;
			if (irq_take) next_pc <= irq_vector + 11'h001;
			else if (irq_return) next_pc <= return_pc;
		end
	end
endmodule // itbu_core_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the interrupt and time base unit
`timescale 1ns/1ps
`default_nettype none
`include "itbu_defines.svh"
module testbench;
	import itbu_pkg::*;
	logic clk, nrst, hsel, hwrite, pin, filt, sleep, do_ret, ho, hr, pull, take, iret, full;
	logic wake, ct, rfi, sub, fsel, dirin, psel;
	logic [2:0] ser, hsize;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata;
	itbu_pc_t npc, vo, ro, vec, rpc;
	int failures, total_checks, ntake, nwake;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	itbu_top uut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(ho), .hrdata(hrdata),
		.hreadyout(ho), .hresp(hr), .pin_in(pin), .pin_func_sel(fsel), .pin_dir_in(dirin),
		.pin_pullup_sel(psel), .pin_pullup_en(pull), .filter_output_ready(filt),
		.ser_byte_done(ser[0]), .ser_addr_match(ser[1]), .ser_bus_timeout(ser[2]),
		.sub_clk_tick(sub), .next_pc(npc), .core_can_take(ct), .return_from_interrupt(rfi),
		.sleep_mode(sleep), .irq_take(take), .irq_vector(vo), .irq_return(iret),
		.return_pc(ro), .stack_full(full), .wake_up(wake));
	itbu_core_model core (.clk(clk), .nrst(nrst), .irq_take(take), .irq_vector(vo),
		.irq_return(iret), .return_pc(ro), .do_ret(do_ret), .next_pc(npc),
		.core_can_take(ct), .return_from_interrupt(rfi));
	// ----
	// tasks
	// ----
	task automatic print_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (ho !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (ho !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(n, e, x);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic ret;
		@(posedge clk);
		do_ret <= 1'b1;
		@(posedge clk);
		do_ret <= 1'b0;
		wt(6);
	endtask
	always @(posedge clk) begin
		if (take === 1'b1) begin
			ntake++;
			vec = vo;
		end
		if (iret === 1'b1) rpc = ro;
		if (wake === 1'b1) nwake++;
	end
	initial begin
		wt(20000);
		failures++;
		print_verdict();
	end
	// ----
	// scenarios
	// ----
	initial begin
		{nrst, hsel, hwrite, pin, filt, sleep, do_ret, ser, htrans, haddr, hwdata, sub} = '0;
		{fsel, dirin, psel} = 3'h7;
		hsize = 3'h2;
		wt(3);
		nrst <= 1'b1;
		rdc("psc", `ITBU_OFS_PSC, 32'h0);
		rdc("tb1", `ITBU_OFS_TB1, 32'h0);
		wr(`ITBU_OFS_TB0, 32'hFF);
		rdc("tb0", `ITBU_OFS_TB0, 32'h87);
		wr(`ITBU_OFS_TB0, 32'h0);
		rdc("unmapped", 12'h040, 32'h0);
		wr(`ITBU_OFS_EDGE, 32'h1);
		wr(`ITBU_OFS_CTRL, 32'h3);
		pin <= 1'b1;
		wt(6);
		chk("pin vec", 32'h4, {21'h0, vec});
		rdc("flags", `ITBU_OFS_FLAG, 32'h0);
		rdc("ctrl", `ITBU_OFS_CTRL, 32'h2);
		ret();
		chk("ret pc", 32'h123, {21'h0, rpc});
		wr(`ITBU_OFS_CTRL, 32'h2);
		pin <= 1'b0;
		for (int e = 0; e < 4; e++) begin
			wr(`ITBU_OFS_EDGE, 32'(e));
			wr(`ITBU_OFS_FLAG, 32'h0);
			pin <= 1'b1;
			wt(3);
			rdc("rise", `ITBU_OFS_FLAG, 32'(e & 1));
			wr(`ITBU_OFS_FLAG, 32'h0);
			pin <= 1'b0;
			wt(3);
			rdc("fall", `ITBU_OFS_FLAG, 32'((e >> 1) & 1));
		end
		wr(`ITBU_OFS_FLAG, 32'h0);
		fsel <= 1'b0;
		pin <= 1'b1;
		wt(3);
		rdc("no func", `ITBU_OFS_FLAG, 32'h0);
		fsel <= 1'b1;
		dirin <= 1'b0;
		pin <= 1'b0;
		wt(3);
		rdc("no input", `ITBU_OFS_FLAG, 32'h0);
		dirin <= 1'b1;
		psel <= 1'b0;
		wt(1);
		chk("pullup", 32'h0, {31'h0, pull});
		wr(`ITBU_OFS_CTRL, 32'h4);
		filt <= 1'b1;
		wt(6);
		chk("no take", 32'h1, ntake);
		rdc("filt flag", `ITBU_OFS_FLAG, 32'h2);
		wr(`ITBU_OFS_FLAG, 32'h6);
		wr(`ITBU_OFS_CTRL, 32'hD);
		wt(6);
		chk("prio vec", 32'h8, {21'h0, vec});
		for (int i = 0; i < 3; i++) begin
			wr(`ITBU_OFS_CTRL, 32'h9);
			wt(4);
			wr(`ITBU_OFS_FLAG, 32'h4);
		end
		wr(`ITBU_OFS_CTRL, 32'h9);
		wt(6);
		chk("full", 32'h5, ntake);
		rdc("stat", `ITBU_OFS_STAT, 32'hC);
		ret();
		chk("after pop", 32'h6, ntake);
		chk("ret pc2", 32'h00D, {21'h0, rpc});
		sleep <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(`ITBU_OFS_FLAG, 32'h0);
			ser <= 3'(1 << i);
			@(posedge clk);
			ser <= 3'h0;
			wt(3);
			rdc("ser flag", `ITBU_OFS_FLAG, 32'h4);
		end
		ser <= 3'h1;
		@(posedge clk);
		ser <= 3'h0;
		wt(3);
		chk("wakes", 32'h3, nwake);
		sleep <= 1'b0;
		wr(`ITBU_OFS_FLAG, 32'h0);
		wr(`ITBU_OFS_TB0, 32'h80);
		wt(120);
		rdc("tb0 early", `ITBU_OFS_FLAG, 32'h0);
		wt(200);
		rdc("tb0 flag", `ITBU_OFS_FLAG, 32'h8);
		wr(`ITBU_OFS_TB0, 32'h0);
		wr(`ITBU_OFS_FLAG, 32'h0);
		wr(`ITBU_OFS_TB1, 32'h81);
		wt(300);
		rdc("tb1 early", `ITBU_OFS_FLAG, 32'h0);
		wt(250);
		rdc("tb1 flag", `ITBU_OFS_FLAG, 32'h10);
		wr(`ITBU_OFS_TB1, 32'h0);
		wr(`ITBU_OFS_PSC, 32'h1);
		wr(`ITBU_OFS_FLAG, 32'h0);
		wr(`ITBU_OFS_TB0, 32'h80);
		wt(900);
		rdc("div4 early", `ITBU_OFS_FLAG, 32'h0);
		wt(200);
		rdc("div4 flag", `ITBU_OFS_FLAG, 32'h8);
		wr(`ITBU_OFS_TB0, 32'h0);
		wr(`ITBU_OFS_PSC, 32'h2);
		wr(`ITBU_OFS_FLAG, 32'h0);
		wr(`ITBU_OFS_TB0, 32'h80);
		wt(300);
		rdc("sub stopped", `ITBU_OFS_FLAG, 32'h0);
		sub <= 1'b1;
		wt(300);
		rdc("sub flag", `ITBU_OFS_FLAG, 32'h8);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
